// ### design/fsc_classifier.sv
/*
 * Frame static classifier: control detection, security tag parsing and
 * VLAN parsing on the first header bytes of each frame, one result per frame.
 * Assumes frames arrive as byte beats without preamble or FCS, on clk,
 * and a register master that never needs a wait state.
 */
`timescale 1ns/1ps
`default_nettype none
module fsc_classifier
	import fsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Frame beats from the MAC
	input wire fsc_beat_t beat,
	// Classification result to flow lookup
	output fsc_result_t result,
	output logic result_valid
);
	fsc_cfg_t cfg_d, cfg_q;
	logic [31:0] rdata_d, rdata_q;
	logic [7:0] hdr_d [0:29];
	logic [7:0] hdr_q [0:29];
	logic [4:0] cnt_d, cnt_q;
	logic busy_d, busy_q;
	logic done_d, done_q;
	fsc_result_t res_d, res_q;
	logic [3:0] ent_idx;
	logic [2:0] ext_idx;
	logic ent_sel, ext_sel, mapped;

	// Entry decode; entries take two words, extra types one word
	assign ent_idx = 4'((reg_addr - OFF_ENT_BASE) >> 3);
	assign ext_idx = 3'((reg_addr - OFF_EXT_BASE) >> 2);
	assign ent_sel = (reg_addr >= OFF_ENT_BASE) && (reg_addr < OFF_EXT_BASE);
	assign ext_sel = (reg_addr >= OFF_EXT_BASE) && (reg_addr < OFF_TAG_CHECK);

	// Register writes; the pair enable bit covers both halves of entries 8 and 9
	always_comb begin
		cfg_d = cfg_q;
		if (reg_wr) begin
			case (reg_addr)
				OFF_ENABLE: cfg_d.en = reg_wdata[NUM_CRIT-1:0];
				OFF_TSEL: cfg_d.tsel = reg_wdata[0];
				OFF_FULL_LO: cfg_d.full[31:0] = reg_wdata;
				OFF_FULL_HI: cfg_d.full[47:32] = reg_wdata[15:0];
				OFF_PREF_LO: cfg_d.prefix[31:0] = reg_wdata;
				OFF_PREF_HI: cfg_d.prefix[47:32] = reg_wdata[15:0];
				OFF_RLOW_LO: cfg_d.rlow[31:0] = reg_wdata;
				OFF_RLOW_HI: cfg_d.rlow[47:32] = reg_wdata[15:0];
				OFF_RHIGH_LO: cfg_d.rhigh[31:0] = reg_wdata;
				OFF_RHIGH_HI: cfg_d.rhigh[47:32] = reg_wdata[15:0];
				OFF_TAG_CHECK: cfg_d.tchk = reg_wdata[5:0];
				OFF_VLAN_CFG: begin
					cfg_d.qtype = reg_wdata[15:0];
					cfg_d.stype = reg_wdata[31:16];
				end
				OFF_VLAN_EXT: begin
					cfg_d.parse_en = reg_wdata[0];
					cfg_d.prio_en = reg_wdata[1];
					cfg_d.dflt_up = reg_wdata[4:2];
					cfg_d.sec_after_vlan = reg_wdata[5];
				end
				OFF_PRIO_MAP: cfg_d.pmap = reg_wdata[23:0];
				OFF_INNER_MAP: cfg_d.imap = reg_wdata[23:0];
				default: begin
					// Address shares the high word with the type
					if (ent_sel && !reg_addr[2]) begin
						cfg_d.ent_da[ent_idx][31:0] = reg_wdata;
					end else if (ent_sel) begin
						cfg_d.ent_da[ent_idx][47:32] = reg_wdata[15:0];
						cfg_d.ent_et[ent_idx] = reg_wdata[31:16];
					end else if (ext_sel) begin
						cfg_d.ext_et[ext_idx] = reg_wdata[15:0];
					end
				end
			endcase
		end
	end

	// Read mux; unmapped words and bits above a field read as zero
	always_comb begin
		rdata_d = 32'h0;
		mapped = 1'b1;
		case (reg_addr)
			OFF_ENABLE: rdata_d[NUM_CRIT-1:0] = cfg_q.en;
			OFF_TSEL: rdata_d[0] = cfg_q.tsel;
			OFF_FULL_LO: rdata_d = cfg_q.full[31:0];
			OFF_FULL_HI: rdata_d[15:0] = cfg_q.full[47:32];
			OFF_PREF_LO: rdata_d = cfg_q.prefix[31:0];
			OFF_PREF_HI: rdata_d[15:0] = cfg_q.prefix[47:32];
			OFF_RLOW_LO: rdata_d = cfg_q.rlow[31:0];
			OFF_RLOW_HI: rdata_d[15:0] = cfg_q.rlow[47:32];
			OFF_RHIGH_LO: rdata_d = cfg_q.rhigh[31:0];
			OFF_RHIGH_HI: rdata_d[15:0] = cfg_q.rhigh[47:32];
			OFF_TAG_CHECK: rdata_d[5:0] = cfg_q.tchk;
			OFF_VLAN_CFG: rdata_d = {cfg_q.stype, cfg_q.qtype};
			OFF_VLAN_EXT: rdata_d[5:0] = {cfg_q.sec_after_vlan, cfg_q.dflt_up,
				cfg_q.prio_en, cfg_q.parse_en};
			OFF_PRIO_MAP: rdata_d[23:0] = cfg_q.pmap;
			OFF_INNER_MAP: rdata_d[23:0] = cfg_q.imap;
			OFF_STATUS: rdata_d[9:0] = {res_q.qinq, res_q.qtag_valid, res_q.stag_valid,
				res_q.vlan_valid, res_q.up, res_q.tag, res_q.control};
			default: begin
				if (ent_sel && !reg_addr[2]) begin
					rdata_d = cfg_q.ent_da[ent_idx][31:0];
				end else if (ent_sel) begin
					rdata_d = {cfg_q.ent_et[ent_idx], cfg_q.ent_da[ent_idx][47:32]};
				end else if (ext_sel) begin
					rdata_d[15:0] = cfg_q.ext_et[ext_idx];
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
		if (!reg_rd) begin
			rdata_d = 32'h0;
		end
	end

	// Registers; reset leaves every control criterion off
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg_q <= CFG_RESET;
			rdata_q <= 32'h0;
		end else begin
			cfg_q <= cfg_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

	// Header capture; bytes past a short frame stay zero
	always_comb begin
		logic [4:0] idx;
		idx = beat.sof ? 5'h0 : cnt_q;
		hdr_d = hdr_q;
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (beat.valid && (beat.sof || busy_q)) begin
			if (beat.sof) begin
				for (int i = 0; i < 30; i++) begin
					hdr_d[i] = 8'h00;
				end
			end
			hdr_d[idx] = beat.data;
			cnt_d = 5'(idx + 5'h1);
			done_d = (idx == HDR_LAST) || beat.eof;
			busy_d = !done_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			for (int i = 0; i < 30; i++) begin
				hdr_q[i] <= 8'h00;
			end
			cnt_q <= 5'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			hdr_q <= hdr_d;
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	// Field views of the captured header
	logic [47:0] da;
	logic [15:0] et1, et2, et3, tci1, tci2, parsed_et, cmp_et, sec_et;
	logic tag1, tag2, tag1_s, sec_present;
	logic [4:0] sec_base;
	logic [7:0] tci, sl;
	logic [31:0] pn;
	assign da = {hdr_q[0], hdr_q[1], hdr_q[2], hdr_q[3], hdr_q[4], hdr_q[5]};
	assign et1 = {hdr_q[12], hdr_q[13]};
	assign tci1 = {hdr_q[14], hdr_q[15]};
	assign et2 = {hdr_q[16], hdr_q[17]};
	assign tci2 = {hdr_q[18], hdr_q[19]};
	assign et3 = {hdr_q[20], hdr_q[21]};

	// VLAN parsing of up to two stacked tags
	assign tag1 = cfg_q.parse_en && (et1 == cfg_q.qtype || et1 == cfg_q.stype);
	assign tag1_s = et1 == cfg_q.stype;
	assign tag2 = tag1 && (et2 == cfg_q.qtype || et2 == cfg_q.stype);
	assign parsed_et = tag2 ? et3 : (tag1 ? et2 : et1);

	// Security tag sits after the source address unless bypass mode lets it trail tags
	assign sec_base = !cfg_q.sec_after_vlan ? 5'h0C : (tag2 ? 5'h14 : (tag1 ? 5'h10 : 5'h0C));
	assign sec_et = cfg_q.sec_after_vlan ? parsed_et : et1;
	assign sec_present = sec_et == SEC_ETYPE;
	assign tci = hdr_q[5'(sec_base + 5'h2)];
	assign sl = hdr_q[5'(sec_base + 5'h3)];
	assign pn = {hdr_q[5'(sec_base + 5'h4)], hdr_q[5'(sec_base + 5'h5)],
		hdr_q[5'(sec_base + 5'h6)], hdr_q[5'(sec_base + 5'h7)]};

	// Control criteria; type source chosen by software
	logic [NUM_CRIT-1:0] hit;
	logic [9:0] ent_da_hit, ent_et_hit;
	assign cmp_et = cfg_q.tsel ? parsed_et : et1;
	assign hit[EN_FULL] = da == cfg_q.full;
	assign hit[EN_PREFIX] = (da | {44'h0, PREFIX_DONT_CARE}) ==
		(cfg_q.prefix | {44'h0, PREFIX_DONT_CARE});
	// Unsigned inclusive bounds, and
	assign hit[EN_RANGE] = (da >= cfg_q.rlow) && (da <= cfg_q.rhigh);

	generate
		for (genvar g = 0; g < 10; g++) begin : g_ent
			assign ent_da_hit[g] = da == cfg_q.ent_da[g];
			assign ent_et_hit[g] = cmp_et == cfg_q.ent_et[g];
			if (g < 8) begin : g_single
				// Independent address and type bits, and
				assign hit[EN_DA0 + g] = ent_da_hit[g];
				assign hit[EN_ET0 + g] = ent_et_hit[g];
				assign hit[EN_ET10 + g] = cmp_et == cfg_q.ext_et[g];
			end else begin : g_pair
				// One enable bit, both halves must match
				assign hit[EN_PAIR8 + g - 8] = ent_da_hit[g] && ent_et_hit[g];
			end
		end
	endgenerate

	// Result computation, all three operations side by side
	always_comb begin
		res_d = res_q;
		if (done_q) begin
			res_d.control = |(hit & cfg_q.en);
			// Fixed check order, first hit decides
			if (!sec_present) begin
				res_d.tag = TAG_UNTAGGED;
			end else if (cfg_q.tchk[0] && tci[7]) begin
				res_d.tag = TAG_BAD;
			end else if (!tci[2] && tci[3]) begin
				res_d.tag = TAG_KAY;
			end else if (cfg_q.tchk[1] && tci[2] && !tci[3]) begin
				res_d.tag = TAG_BAD;
			end else if (cfg_q.tchk[2] && tci[5] && tci[6]) begin
				res_d.tag = TAG_BAD;
			end else if (cfg_q.tchk[3] && tci[5] && tci[4]) begin
				res_d.tag = TAG_BAD;
			end else if (cfg_q.tchk[4] && sl[5:0] >= SL_LIMIT) begin
				res_d.tag = TAG_BAD;
			end else if (cfg_q.tchk[5] && pn == 32'h0) begin
				res_d.tag = TAG_BAD;
			end else begin
				res_d.tag = TAG_TAGGED;
			end
			// Flags from the first tag's type; Q-in-Q from a matching second tag
			res_d.vlan_valid = tag1;
			res_d.stag_valid = tag1 && tag1_s;
			res_d.qtag_valid = tag1 && !tag1_s;
			res_d.qinq = tag2;
			// Default priority when untagged or processing is off
			res_d.up = (tag1 && cfg_q.prio_en) ? cfg_q.pmap[3 * tci1[15:13] +: 3] : cfg_q.dflt_up;
			res_d.vid = tci1[11:0];
			res_d.inner_up = cfg_q.imap[3 * tci2[15:13] +: 3];
			res_d.inner_vid = tci2[11:0];
			res_d.ethertype = parsed_et;
		end
	end

	// Result hold and one-cycle valid pulse
	always_ff @(posedge clk) begin
		if (!rstn) begin
			res_q <= '0;
			result_valid <= 1'b0;
		end else begin
			res_q <= res_d;
			result_valid <= done_q;
		end
	end

	assign result = res_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_result_follows: assert property (done_q |=> result_valid)
		else $error("result valid missing after header");
	a_ctl_all_off: assert property (done_q && cfg_q.en == '0 |=> !result.control)
		else $error("control set with no criterion enabled");
	a_ctl_enabled_hit: assert property (done_q && |(hit & cfg_q.en) |=> result.control)
		else $error("enabled criterion hit but control clear");
	a_range_single: assert property (done_q && cfg_q.en[EN_RANGE] && cfg_q.rlow == cfg_q.rhigh
		&& da == cfg_q.rlow |=> result.control)
		else $error("single address range did not match");
	a_untagged_type: assert property (done_q && !sec_present |=> result.tag == TAG_UNTAGGED)
		else $error("non security type not untagged");
	a_kay_class: assert property (done_q && sec_present && !tci[7] && !tci[2] && tci[3]
		|=> result.tag == TAG_KAY)
		else $error("key agreement frame misclassed");
	a_vbit_bad: assert property (done_q && sec_present && cfg_q.tchk[0] && tci[7]
		|=> result.tag == TAG_BAD)
		else $error("V bit frame not bad tag");
	a_qinq_flags: assert property (result_valid && result.qinq |-> result.vlan_valid
		&& (result.stag_valid != result.qtag_valid))
		else $error("Q-in-Q without consistent first tag flags");
	a_default_up: assert property (done_q && !tag1 |=> result.up == $past(cfg_q.dflt_up))
		else $error("untagged frame without default priority");
	a_unmapped_zero: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ### design/fsc_pkg.sv
/*
 * Package of the frame static classifier: register offsets, reset values,
 * configuration layout, frame beat and result carriers.
 * Assumes a 32-bit plain register port and byte-wide frame beats.
 */
`default_nettype none
package fsc_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_ENABLE = 8'h00;
	localparam logic [7:0] OFF_TSEL = 8'h04;
	localparam logic [7:0] OFF_FULL_LO = 8'h08;
	localparam logic [7:0] OFF_FULL_HI = 8'h0C;
	localparam logic [7:0] OFF_PREF_LO = 8'h10;
	localparam logic [7:0] OFF_PREF_HI = 8'h14;
	localparam logic [7:0] OFF_RLOW_LO = 8'h18;
	localparam logic [7:0] OFF_RLOW_HI = 8'h1C;
	localparam logic [7:0] OFF_RHIGH_LO = 8'h20;
	localparam logic [7:0] OFF_RHIGH_HI = 8'h24;
	localparam logic [7:0] OFF_ENT_BASE = 8'h40;
	localparam logic [7:0] OFF_EXT_BASE = 8'h90;
	localparam logic [7:0] OFF_TAG_CHECK = 8'hB0;
	localparam logic [7:0] OFF_VLAN_CFG = 8'hB4;
	localparam logic [7:0] OFF_VLAN_EXT = 8'hB8;
	localparam logic [7:0] OFF_PRIO_MAP = 8'hBC;
	localparam logic [7:0] OFF_INNER_MAP = 8'hC0;
	localparam logic [7:0] OFF_STATUS = 8'hC4;
	// Enable mask bit positions
	localparam int EN_FULL = 0;
	localparam int EN_PREFIX = 1;
	localparam int EN_RANGE = 2;
	localparam int EN_DA0 = 3;
	localparam int EN_ET0 = 11;
	localparam int EN_PAIR8 = 19;
	localparam int EN_ET10 = 21;
	localparam int NUM_CRIT = 29;
	// Header capture and frame constants
	localparam logic [4:0] HDR_LAST = 5'h1D;
	localparam logic [15:0] SEC_ETYPE = 16'h88E5;
	localparam logic [5:0] SL_LIMIT = 6'h30;
	localparam logic [3:0] PREFIX_DONT_CARE = 4'hF;
	// Reset values
	localparam logic [47:0] RST_FULL = 48'h01000CCCCCCC;
	localparam logic [47:0] RST_PREFIX = 48'h0180C2000000;
	localparam logic [15:0] RST_QTYPE = 16'h8100;
	localparam logic [15:0] RST_STYPE = 16'h88A8;
	localparam logic [23:0] RST_MAP = 24'hFAC688;
	localparam logic [5:0] RST_TCHK = 6'h3F;

	typedef enum logic [1:0] {TAG_UNTAGGED, TAG_TAGGED, TAG_BAD, TAG_KAY} fsc_tag_t;

	typedef struct packed {
		logic [NUM_CRIT-1:0] en;
		logic tsel;
		logic [47:0] full;
		logic [47:0] prefix;
		logic [47:0] rlow;
		logic [47:0] rhigh;
		logic [9:0][47:0] ent_da;
		logic [9:0][15:0] ent_et;
		logic [7:0][15:0] ext_et;
		logic [5:0] tchk;
		logic [15:0] qtype;
		logic [15:0] stype;
		logic parse_en;
		logic prio_en;
		logic [2:0] dflt_up;
		logic sec_after_vlan;
		logic [23:0] pmap;
		logic [23:0] imap;
	} fsc_cfg_t;

	localparam fsc_cfg_t CFG_RESET = '{full: RST_FULL, prefix: RST_PREFIX, tchk: RST_TCHK,
		qtype: RST_QTYPE, stype: RST_STYPE, parse_en: 1'b1, prio_en: 1'b1,
		pmap: RST_MAP, imap: RST_MAP, default: '0};

	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [7:0] data;
	} fsc_beat_t;

	typedef struct packed {
		logic control;
		fsc_tag_t tag;
		logic vlan_valid;
		logic stag_valid;
		logic qtag_valid;
		logic qinq;
		logic [2:0] up;
		logic [11:0] vid;
		logic [2:0] inner_up;
		logic [11:0] inner_vid;
		logic [15:0] ethertype;
	} fsc_result_t;
endpackage
`default_nettype wire

// ### testbench/fsc_mac_model.sv
/*
 * MAC-side model: plays one frame of 1 to 30 bytes as byte beats.
 * Assumes the bench loads frame and last index, then pulses go while idle.
 */
`timescale 1ns/1ps
`default_nettype none
module fsc_mac_model
	import fsc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Frame request
	input wire logic go,
	input wire logic [0:29][7:0] frame,
	input wire logic [4:0] last,
	// Beats to the classifier
	output fsc_beat_t beat,
	output logic busy
);
	logic [4:0] idx;

	// One byte a cycle; idle data toggles so a stale byte never repeats
	always @(posedge clk) begin
		if (!rstn) begin
			busy <= 1'b0;
			idx <= 5'h00;
			beat <= '0;
		end else if (busy || go) begin
			beat <= '{valid: 1'b1, sof: !busy, eof: (idx == last), data: frame[idx]};
			idx <= idx + 5'h01;
			busy <= (idx != last);
		end else begin
			beat <= '{valid: 1'b0, sof: 1'b0, eof: 1'b0, data: ~beat.data};
			idx <= 5'h00;
		end
	end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
/*
 * Self-checking bench of the frame static classifier: table of frames, then
 * register and corner cases by hand.
 * Assumes the MAC model in its own file and the design package.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench import fsc_pkg::*;;
	localparam logic [47:0] NDA = 48'h0A0000000009;
	logic clk, rstn, reg_wr, reg_rd, go, result_valid, busy;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [0:29][7:0] frame;
	logic [4:0] last;
	fsc_beat_t beat;
	fsc_result_t result;
	int fail_count, check_count;
	logic [0:29][7:0] fq[$];
	logic [25:0] eq[$];

	fsc_classifier dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .beat(beat),
		.result(result), .result_valid(result_valid));
	fsc_mac_model mac (.clk(clk), .rstn(rstn), .go(go), .frame(frame), .last(last),
		.beat(beat), .busy(busy));

	// Frame builders: header bytes in wire order, byte 0 first
	function automatic logic [0:29][7:0] mk(input logic [47:0] da, input logic [15:0] et,
		input logic [127:0] rest);
		return {da, 48'h0A0B0C0D0E0F, et, rest};
	endfunction
	function automatic logic [0:29][7:0] sec(input logic [7:0] tci, input logic [7:0] sl,
		input logic [31:0] pn);
		return mk(NDA, SEC_ETYPE, {tci, sl, pn, 80'h0});
	endfunction
	function automatic logic [25:0] ex(input logic c, input fsc_tag_t t, input logic [3:0] v,
		input logic [2:0] u, input logic [15:0] e);
		return {c, t, v, u, e};
	endfunction
	function automatic logic [25:0] got();
		return {result.control, result.tag, result.vlan_valid, result.stag_valid,
			result.qtag_valid, result.qinq, result.up, result.ethertype};
	endfunction

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// One-cycle register strobes, changed just after the edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check("register read", reg_rdata, e);
	endtask

	// Plays n bytes, waits a bounded time for the one-cycle result pulse
	task automatic send(input logic [0:29][7:0] f, input int n);
		int k;
		@(posedge clk);
		frame <= f;
		last <= 5'(n - 1);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		for (k = 1; k < 60; k++) begin
			@(posedge clk);
			#1;
			if (result_valid === 1'b1)
				break;
		end
		check("result latency", k, n + 1);
		if (k == 60)
			print_verdict();
		@(posedge clk);
		#1;
		check("result pulse", result_valid, 0);
	endtask

	task automatic row(input logic [0:29][7:0] f, input logic [25:0] e);
		fq.push_back(f);
		eq.push_back(e);
	endtask

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		rstn = 1'b0;
		{reg_wr, reg_rd, go, reg_addr, reg_wdata, last} = '0;
		frame = '0;
		fail_count = 0;
		check_count = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		#1;
		check("reset result", {result_valid, result}, 0);
		rd_chk(OFF_ENABLE, 32'h00000000);
		rd_chk(OFF_FULL_LO, 32'h0CCCCCCC);
		rd_chk(OFF_FULL_HI, 32'h00000100);
		rd_chk(OFF_PREF_HI, 32'h00000180);
		rd_chk(OFF_VLAN_CFG, 32'h88A88100);
		rd_chk(8'hFC, 32'h00000000);
		send(mk(RST_FULL, 16'h0800, '0), 30);
		check("disabled criteria", result.control, 0);
		// Range of one address, entry 0, pair 8, type 10
		wr(OFF_RLOW_LO, 32'h00000005);
		wr(OFF_RLOW_HI, 32'h00000200);
		wr(OFF_RHIGH_LO, 32'h00000005);
		wr(OFF_RHIGH_HI, 32'h00000200);
		wr(OFF_ENT_BASE, 32'h00000001);
		wr(OFF_ENT_BASE + 8'h04, 32'h888E0A00);
		wr(OFF_ENT_BASE + 8'h40, 32'h00000008);
		wr(OFF_ENT_BASE + 8'h44, 32'h22F00A00);
		wr(OFF_EXT_BASE, 32'h00001234);
		wr(OFF_ENABLE, 32'h0028080F);
		rd_chk(OFF_ENABLE, 32'h0028080F);
		row(mk(RST_FULL, 16'h0800, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(48'h0180C200000E, 16'h0800, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(48'h0180C200001E, 16'h0800, '0), ex(0, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(48'h020000000005, 16'h0800, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(48'h020000000006, 16'h0800, '0), ex(0, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(48'h020000000004, 16'h0800, '0), ex(0, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(48'h0A0000000001, 16'h0800, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(NDA, 16'h888E, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h888E));
		row(mk(NDA, 16'h1234, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h1234));
		row(mk(48'h0A0000000008, 16'h22F0, '0), ex(1, TAG_UNTAGGED, 0, 0, 16'h22F0));
		row(mk(48'h0A0000000008, 16'h0800, '0), ex(0, TAG_UNTAGGED, 0, 0, 16'h0800));
		row(mk(NDA, 16'h22F0, '0), ex(0, TAG_UNTAGGED, 0, 0, 16'h22F0));
		row(sec(8'h00, 8'h00, 32'h1), ex(0, TAG_TAGGED, 0, 0, SEC_ETYPE));
		row(sec(8'h0C, 8'h00, 32'h1), ex(0, TAG_TAGGED, 0, 0, SEC_ETYPE));
		row(sec(8'h08, 8'h00, 32'h1), ex(0, TAG_KAY, 0, 0, SEC_ETYPE));
		row(sec(8'h88, 8'h00, 32'h1), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(sec(8'h08, 8'h30, 32'h1), ex(0, TAG_KAY, 0, 0, SEC_ETYPE));
		row(sec(8'h80, 8'h00, 32'h1), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(sec(8'h04, 8'h00, 32'h1), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(sec(8'h60, 8'h00, 32'h1), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(sec(8'h30, 8'h00, 32'h1), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(sec(8'h20, 8'h00, 32'h1), ex(0, TAG_TAGGED, 0, 0, SEC_ETYPE));
		row(sec(8'h00, 8'h30, 32'h1), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(sec(8'h00, 8'h2F, 32'h1), ex(0, TAG_TAGGED, 0, 0, SEC_ETYPE));
		row(sec(8'h00, 8'h00, 32'h0), ex(0, TAG_BAD, 0, 0, SEC_ETYPE));
		row(mk(NDA, 16'h8100, {16'hA123, 16'h0800, 96'h0}),
			ex(0, TAG_UNTAGGED, 4'hA, 3'h5, 16'h0800));
		row(mk(NDA, 16'h88A8, {16'h2456, 16'h8100, 16'h6789, 16'h86DD, 64'h0}),
			ex(0, TAG_UNTAGGED, 4'hD, 3'h1, 16'h86DD));
		row(mk(NDA, 16'h8100, {16'h2123, 16'h888E, 96'h0}),
			ex(0, TAG_UNTAGGED, 4'hA, 3'h1, 16'h888E));
		row(mk(NDA, 16'h8100, {16'h0001, SEC_ETYPE, 8'h00, 8'h00, 32'h1, 48'h0}),
			ex(0, TAG_UNTAGGED, 4'hA, 3'h0, SEC_ETYPE));
		foreach (fq[i]) begin
			send(fq[i], 30);
			check("row result", got(), eq[i]);
		end
		// Inner fields and status word, then a reversed inner priority map
		send(fq[fq.size() - 3], 30);
		check("ids", {result.vid, result.inner_vid}, 24'h456789);
		check("inner priority", result.inner_up, 3'h3);
		rd_chk(OFF_STATUS, 32'h000002C8);
		wr(OFF_INNER_MAP, 32'h00053977);
		send(fq[fq.size() - 3], 30);
		check("remapped inner", {result.up, result.inner_up}, 6'o14);
		// Priority processing off returns the default priority
		wr(OFF_VLAN_EXT, 32'h00000019);
		send(fq[fq.size() - 4], 30);
		check("default priority", result.up, 3'h6);
		wr(OFF_TSEL, 32'h00000001);
		send(fq[fq.size() - 2], 30);
		check("parsed type select", result.control, 1);
		wr(OFF_VLAN_EXT, 32'h00000023);
		send(fq[fq.size() - 1], 30);
		check("tag after vlan", result.tag, TAG_TAGGED);
		// Short frames: missing bytes read as zero
		send(mk(NDA, SEC_ETYPE, '0), 14);
		check("short frame", result.tag, TAG_BAD);
		send(mk(NDA, SEC_ETYPE, '0), 1);
		wr(OFF_TAG_CHECK, 32'h0000001F);
		send(sec(8'h00, 8'h00, 32'h0), 30);
		check("check disabled", result.tag, TAG_TAGGED);
		wr(OFF_FULL_LO, 32'h11111111);
		send(mk(48'h010011111111, 16'h0800, '0), 30);
		check("rewritten address", result.control, 1);
		// Reset in mid-run must bring back the reset configuration
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		check("mid-run reset result", {result_valid, result}, 0);
		rd_chk(OFF_ENABLE, 32'h00000000);
		rd_chk(OFF_FULL_LO, 32'h0CCCCCCC);
		send(mk(RST_FULL, 16'h0800, '0), 30);
		check("control after reset", result.control, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
